// file: host_model.sv
// Host master model: register access and attention scans
module host_model
    import rate_ctrl_pkg::*;
(
    input  wire logic        CLK,
    output reg_req_type      REG_REQ,
    input  wire logic [15:0] REG_RDATA,
    input  wire logic        REG_RVALID,
    input  wire logic        ATTENTION
);
    timeunit 1ns;
    timeprecision 100ps;
    int scans = 0;  // Scans made on attention
    initial REG_REQ = '0;
    // One scan per attention, so scan rate equals conversion rate
    always @(posedge CLK) if (ATTENTION === 1'b1) scans <= scans + 1;
    // Write strobe for one cycle; host software sets the rate itself
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge CLK);
        #2 REG_REQ = '{1'b1, 1'b0, a, v};
        @(posedge CLK);
        #2 REG_REQ = '0;
    endtask
    // Read strobe; data stands for one cycle after the taking edge, so grab it then
    task automatic rd(input logic [5:0] a, output logic [15:0] v);
        @(posedge CLK);
        #2 REG_REQ = '{1'b0, 1'b1, a, 16'h0000};
        @(posedge CLK);
        #2 REG_REQ = '0;
        v = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hXXXX;
    endtask
endmodule // host_model

// file: rate_ctrl_cfg.svh
// Constants for the conversion-rate control block: offsets, fields, resets, timing
`ifndef RATE_CTRL_CFG_SVH
`define RATE_CTRL_CFG_SVH

// ****************************************
// Register offsets (6-bit register address)
// ****************************************
`define RATE_ADDR            6'h20
`define TEMP_CTRL_ADDR       6'h0A

// ****************************************
// Field positions
// ****************************************
`define RATE_CODE_LSB        0
`define RATE_CODE_MSB        1
`define ATTN_EN_BIT          0
`define LOCAL_EN_BIT         1
`define REMOTE1_EN_BIT       2
`define REMOTE2_EN_BIT       3

// ****************************************
// Reset values
// ****************************************
`define RATE_RESET           2'h2
`define TEMP_CTRL_RESET      4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ              40
`define ZONE_TIME_US         7500
`define ZONE_CYCLES          (`ZONE_TIME_US * `CLK_MHZ)
`define BASE_INTERVAL_MS     91
`define BASE_INTERVAL_CYCLES (`BASE_INTERVAL_MS * 1000 * `CLK_MHZ)

`endif

// file: rate_ctrl_pkg.sv
// Types shared by the conversion-rate control block
package rate_ctrl_pkg;

    // ****************************************
    // Register access request
    // ****************************************
    typedef struct packed {
        logic        write;  // One-cycle write strobe
        logic        read;   // One-cycle read strobe
        logic [5:0]  addr;   // Register address
        logic [15:0] wdata;  // Write data
    } reg_req_type;

    // Temperature control fields, bit 0 first from the right
    typedef struct packed {
        logic remote_zone2_enable;
        logic remote_zone1_enable;
        logic local_zone_enable;
        logic attention_enable;
    } temp_ctrl_type;

    // Rate code field
    typedef struct packed {
        logic rate_code_high;
        logic rate_code_low;
    } rate_code_type;

    // Round sequencer states
    typedef enum logic {
        WAIT_TICK,
        CONVERT
    } round_state_type;

endpackage

// file: rate_ctrl_sva.sv
// Port checker for the rate control block
`include "rate_ctrl_cfg.svh"
module rate_ctrl_sva
    import rate_ctrl_pkg::*;
#(
    parameter int unsigned ZONE_CYCLES = 4  // Zone repeat below assumes 4
) (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire reg_req_type REG_REQ,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_RVALID,
    input wire logic [2:0]  ZONE_ACTIVE,
    input wire logic        ROUND_BUSY,
    input wire logic        ATTENTION
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_local; (ZONE_ACTIVE == 3'h1) [*4]; endsequence
    sequence s_end; !ROUND_BUSY && $past(ROUND_BUSY); endsequence
    property p_rd; REG_REQ.read |=> REG_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read unanswered");
    property p_rate; REG_RVALID && $past(REG_REQ.addr) == `RATE_ADDR
        |-> REG_RDATA[15:2] == 14'h0000; endproperty
    a_rate: assert property (p_rate) else $error("rate high bits");
    property p_ctl; REG_RVALID && $past(REG_REQ.addr) == `TEMP_CTRL_ADDR
        |-> REG_RDATA[15:4] == 12'h000; endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl high bits");
    property p_hot; $onehot0(ZONE_ACTIVE); endproperty
    a_hot: assert property (p_hot) else $error("two zones");
    property p_zone; $rose(ZONE_ACTIVE[0]) |-> s_local ##1 ZONE_ACTIVE != 3'h1; endproperty
    a_zone: assert property (p_zone) else $error("zone time");
    property p_aend; ATTENTION |-> s_end; endproperty
    a_aend: assert property (p_aend) else $error("attention off end");
    property p_apul; ATTENTION |=> !ATTENTION; endproperty
    a_apul: assert property (p_apul) else $error("attention long");
    property p_bst; $rose(ROUND_BUSY) |-> ZONE_ACTIVE != 3'h0; endproperty
    a_bst: assert property (p_bst) else $error("empty round");
endmodule // rate_ctrl_sva

// file: temp_conversion_rate_control.sv
// Conversion-rate control: register file, interval timer and zone round sequencer
//
// Function
// R1 - Rate register at 20h, resets to 2h
// R2 - Rate register bits 7:2 read zero
// R3 - Normal power: continuous, 91, 182, 364 ms
// R4 - Low power: 91, 364, 728, 1456 ms
// R5 - Continuous: back-to-back 7.5 ms zones
// R6 - One attention pulse per conversion round
// R7 - Host software sets non-default rate itself
// R8 - Attention needs enable and any zone enabled
// R9 - Zone enables gate measurement, reset disabled
// R10 - Interval tick starts round, skips disabled zones
`include "rate_ctrl_cfg.svh"

module temp_conversion_rate_control
    import rate_ctrl_pkg::*;
#(
    parameter int unsigned ZONE_CYCLES          = `ZONE_CYCLES,          // Per-zone time
    parameter int unsigned BASE_INTERVAL_CYCLES = `BASE_INTERVAL_CYCLES  // 91 ms unit
) (
    input  wire logic          CLK,
    input  wire logic          RST_N,
    input  wire reg_req_type   REG_REQ,
    input  wire logic          LOW_POWER_SELECT,
    output logic        [15:0] REG_RDATA,
    output logic               REG_RVALID,
    output logic        [2:0]  ZONE_ACTIVE,
    output logic               ROUND_BUSY,
    output logic               ATTENTION
);

    // ****************************************
    // Registers
    // ****************************************
    rate_code_type   rate;               // Conversion interval select
    temp_ctrl_type   ctrl;               // Attention and zone enables
    round_state_type state;              // Round sequencer state
    logic [31:0]     interval_count;     // Counts down to the next tick
    logic [31:0]     zone_count;         // Counts down the current zone
    logic [1:0]      zone;               // Zone now converting
    logic [31:0]     interval_cycles;    // Selected interval length
    logic            continuous;         // Back-to-back mode
    logic            tick;               // Interval expiry
    logic [2:0]      zone_enables;       // Enables as a vector
    logic [1:0]      next_zone;          // Next enabled zone after current
    logic            next_valid;         // Such a zone exists
    logic [1:0]      first_zone;         // First enabled zone
    logic            first_valid;        // Any zone enabled
    logic            round_done;         // Last zone of the round ended

    assign zone_enables = {ctrl.remote_zone2_enable, ctrl.remote_zone1_enable,
                           ctrl.local_zone_enable};

    // ****************************************
    // Register writes
    // ****************************************

    // Rate register; bits above the code are not stored
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rate <= `RATE_RESET;                                     // R1
        end else if (REG_REQ.write && REG_REQ.addr == `RATE_ADDR) begin
            rate <= REG_REQ.wdata[`RATE_CODE_MSB:`RATE_CODE_LSB];    // R1
        end
    end

    // Temperature control register; everything disabled out of reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl <= `TEMP_CTRL_RESET;                                // R8 R9
        end else if (REG_REQ.write && REG_REQ.addr == `TEMP_CTRL_ADDR) begin
            ctrl.attention_enable    <= REG_REQ.wdata[`ATTN_EN_BIT];
            ctrl.local_zone_enable   <= REG_REQ.wdata[`LOCAL_EN_BIT];
            ctrl.remote_zone1_enable <= REG_REQ.wdata[`REMOTE1_EN_BIT];
            ctrl.remote_zone2_enable <= REG_REQ.wdata[`REMOTE2_EN_BIT];
        end
    end

    // ****************************************
    // Register reads
    // ****************************************

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA  <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_REQ.read;
            REG_RDATA  <= 16'h0000;
            if (REG_REQ.read) begin
                case (REG_REQ.addr)
                    `RATE_ADDR: begin
                        REG_RDATA <= {14'h0000, rate};               // R2
                    end
                    `TEMP_CTRL_ADDR: begin
                        REG_RDATA <= {12'h000, ctrl};                // Reserved as zero
                    end
                    default: begin
                        REG_RDATA <= 16'h0000;                       // Unmapped
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Interval selection
    // ****************************************

    // Every interval is a power-of-two multiple of the 91 ms unit
    always_comb begin
        continuous      = 1'b0;
        interval_cycles = BASE_INTERVAL_CYCLES;
        case ({LOW_POWER_SELECT, rate})
            3'h0: continuous      = 1'b1;                            // R3 R5
            3'h1: interval_cycles = BASE_INTERVAL_CYCLES;            // R3
            3'h2: interval_cycles = 32'(BASE_INTERVAL_CYCLES * 2);   // R3
            3'h3: interval_cycles = 32'(BASE_INTERVAL_CYCLES * 4);   // R3
            3'h4: interval_cycles = BASE_INTERVAL_CYCLES;            // R4
            3'h5: interval_cycles = 32'(BASE_INTERVAL_CYCLES * 4);   // R4
            3'h6: interval_cycles = 32'(BASE_INTERVAL_CYCLES * 8);   // R4
            3'h7: interval_cycles = 32'(BASE_INTERVAL_CYCLES * 16);  // R4
            default: interval_cycles = BASE_INTERVAL_CYCLES;
        endcase
    end

    // Tick on expiry; continuous mode ticks whenever the sequencer is idle
    assign tick = continuous ? (state == WAIT_TICK) : (interval_count == 32'h0000_0000);

    // Interval down-counter; a new rate takes effect at the next reload
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            interval_count <= 32'h0000_0000;                         // First tick at once
        end else if (continuous || interval_count == 32'h0000_0000) begin
            interval_count <= interval_cycles - 32'h0000_0001;       // R3 R4
        end else begin
            interval_count <= interval_count - 32'h0000_0001;
        end
    end

    // ****************************************
    // Zone order: local, remote 1, remote 2
    // ****************************************

    // Next enabled zone strictly after the current one
    always_comb begin
        next_valid = 1'b0;
        next_zone  = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (zone_enables[i] && 2'(i) > zone) begin
                next_valid = 1'b1;                                   // R10
                next_zone  = 2'(i);
            end
        end
    end

    // Lowest enabled zone starts a round
    always_comb begin
        first_valid = 1'b0;
        first_zone  = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (zone_enables[i]) begin
                first_valid = 1'b1;                                  // R9
                first_zone  = 2'(i);
            end
        end
    end

    assign round_done = (state == CONVERT) && (zone_count == 32'h0000_0000) && !next_valid;

    // ****************************************
    // Round sequencer
    // ****************************************

    // A tick that lands mid-round is dropped; rounds never overlap
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state      <= WAIT_TICK;
            zone       <= 2'h0;
            zone_count <= 32'h0000_0000;
        end else begin
            case (state)
                WAIT_TICK: begin
                    if (tick && first_valid) begin
                        state      <= CONVERT;                       // R10
                        zone       <= first_zone;
                        zone_count <= ZONE_CYCLES - 32'h0000_0001;   // R5
                    end
                end
                CONVERT: begin
                    if (zone_count != 32'h0000_0000) begin
                        zone_count <= zone_count - 32'h0000_0001;
                    end else if (next_valid) begin
                        zone       <= next_zone;                     // R10
                        zone_count <= ZONE_CYCLES - 32'h0000_0001;   // R5
                    end else begin
                        state <= WAIT_TICK;                          // R10
                    end
                end
                default: begin
                    state <= WAIT_TICK;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Zone strobe follows the sequencer; a zone disabled mid-round still finishes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ZONE_ACTIVE <= 3'h0;
            ROUND_BUSY  <= 1'b0;
        end else begin
            ROUND_BUSY  <= (state == CONVERT) && !round_done;
            ZONE_ACTIVE <= 3'h0;
            if (state == WAIT_TICK && tick && first_valid) begin
                ZONE_ACTIVE <= 3'(1 << first_zone);                  // R9
                ROUND_BUSY  <= 1'b1;
            end else if (state == CONVERT && !round_done) begin
                if (zone_count == 32'h0000_0000) begin
                    ZONE_ACTIVE <= 3'(1 << next_zone);
                end else begin
                    ZONE_ACTIVE <= 3'(1 << zone);
                end
            end
        end
    end

    // One attention pulse at the end of each round, if enabled
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ATTENTION <= 1'b0;
        end else begin
            ATTENTION <= round_done && ctrl.attention_enable && (|zone_enables); // R6 R8
        end
    end

endmodule // temp_conversion_rate_control

// file: temp_conversion_rate_control_bench.sv
// Bench for the rate control block
`include "rate_ctrl_cfg.svh"
module temp_conversion_rate_control_bench
    import rate_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Z = 4;   // Short zone time
    localparam int B = 40;  // Short 91 ms unit, above 3*Z+2
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic LOW_POWER_SELECT = 1'b0;
    reg_req_type REG_REQ;
    logic [15:0] REG_RDATA, d, w;
    logic REG_RVALID, ROUND_BUSY, ATTENTION;
    logic [2:0] ZONE_ACTIVE;
    logic [3:0] t;
    int errors = 0, checks = 0, seed = 32'h873B, k, n;
    always #12.5 CLK = ~CLK;  // 40 MHz
    int cyc = 0, last_start = 0;  // Edge count and edge of the latest round start
    logic busy_q = 1'b0;          // Busy as seen one edge earlier
    // Stamp every round start, so back-to-back rounds are timed as well
    always @(posedge CLK) begin
        busy_q <= ROUND_BUSY;
        cyc <= cyc + 1;
        if (ROUND_BUSY === 1'b1 && busy_q === 1'b0) last_start <= cyc;
    end
    temp_conversion_rate_control #(.ZONE_CYCLES(Z), .BASE_INTERVAL_CYCLES(B))
        temp_conversion_rate_control_inst (.CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ),
        .LOW_POWER_SELECT(LOW_POWER_SELECT), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .ZONE_ACTIVE(ZONE_ACTIVE), .ROUND_BUSY(ROUND_BUSY), .ATTENTION(ATTENTION));
    host_model host_model_inst (.CLK(CLK), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .ATTENTION(ATTENTION));
    // Interval in units of B; zero means back to back
    function automatic int mult(logic lp, logic [1:0] c);
        return lp ? (c == 2'h0 ? 1 : 2 << c) : (c == 2'h0 ? 0 : 1 << (c - 2'h1));
    endfunction
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    // Cycles until the next round start, 2000 if none
    task automatic wait_start(output int c);
        logic p;
        p = 1'b1;
        c = 0;
        while (c < 2000 && !(p === 1'b0 && ROUND_BUSY === 1'b1)) begin
            p = ROUND_BUSY;
            @(posedge CLK);
            #1 c++;
        end
    endtask
    // Follow one round: zone order, zone times, attention, host scan
    task automatic round(input logic [3:0] e, output int c);
        int zc [3];
        logic [2:0] last;
        int s0;
        zc = '{0, 0, 0};
        last = 3'h0;
        c = 0;
        s0 = host_model_inst.scans;
        while (ROUND_BUSY === 1'b1 && c < 100) begin
            chk("zone order", 16'h1, 16'(ZONE_ACTIVE >= last));
            last = ZONE_ACTIVE;
            foreach (zc[i]) zc[i] += ZONE_ACTIVE[i];
            @(posedge CLK);
            #1 c++;
        end
        foreach (zc[i]) chk("zone time", 16'(e[i + 1] * Z), 16'(zc[i]));
        chk("attention", 16'(e[0]), 16'(ATTENTION));
        @(posedge CLK);
        #1 c++;
        chk("scans", 16'(s0 + e[0]), 16'(host_model_inst.scans));
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #1000us errors++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge CLK);
        #2 RST_N = 1'b1;
        host_model_inst.rd(`RATE_ADDR, d);
        chk("rate reset", 16'h0002, d);
        host_model_inst.wr(6'h15, 16'hFFFF);
        host_model_inst.rd(6'h3F, d);
        chk("unmapped", 16'h0000, d);
        host_model_inst.wr(`TEMP_CTRL_ADDR, 16'h0001);
        wait_start(n);
        chk("no zones", 16'h07D0, 16'(n));
        $display("test idle done");
        for (int lp = 0; lp < 2; lp++) begin
            for (int c = 0; c < 4; c++) begin
                t = 4'($random(seed));
                if (t[3:1] == 3'h0) t[2] = 1'b1;
                w = 16'($random(seed));
                w[3:0] = t;
                host_model_inst.wr(`TEMP_CTRL_ADDR, w);
                host_model_inst.rd(`TEMP_CTRL_ADDR, d);
                chk("ctrl", {12'h000, t}, d);
                w = 16'($random(seed));
                w[1:0] = 2'(c);
                host_model_inst.wr(`RATE_ADDR, w);
                host_model_inst.rd(`RATE_ADDR, d);
                chk("rate", {14'h0000, w[1:0]}, d);
                LOW_POWER_SELECT = lp[0];
                wait_start(n);
                round(t, k);
                wait_start(n);
                round(t, k);
                wait_start(n);
                n = mult(lp[0], 2'(c));
                n = (n == 0) ? $countones(t[3:1]) * Z + 1 : n * B;
                chk("interval", 16'(n), 16'(cyc - last_start));
                $display("test rate %0d %0d done", lp, c);
            end
        end
        @(posedge CLK);
        #2 RST_N = 1'b0;
        repeat (2) @(posedge CLK);
        #2 RST_N = 1'b1;
        host_model_inst.rd(`RATE_ADDR, d);
        chk("rate reset", 16'h0002, d);
        host_model_inst.rd(`TEMP_CTRL_ADDR, d);
        chk("ctrl reset", 16'h0000, d);
        $display("test reset done");
        close_out;
    end
endmodule // temp_conversion_rate_control_bench
bind temp_conversion_rate_control rate_ctrl_sva #(.ZONE_CYCLES(ZONE_CYCLES)) rate_ctrl_sva_inst (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .ZONE_ACTIVE(ZONE_ACTIVE), .ROUND_BUSY(ROUND_BUSY),
    .ATTENTION(ATTENTION));
